// File: bench/card_model.sv
// Behavioural smart card that never answers its reset
`timescale 1ns/10ps
`default_nettype none
module card_model (
  input wire logic pullup_en, // Pull-up released
  input wire logic io_oe, // Interface pulls I/O low
  input wire logic ground_en, // Contacts grounded
  output logic io_level // I/O contact level
);
  // Pull-up wins only when nobody pulls low; a grounded pin reads 0
  assign io_level = pullup_en && !io_oe && !ground_en;
endmodule : card_model
`default_nettype wire

// File: bench/ccs_asserts.sv
// Port-level assertion checker for the card contact sequencer
`timescale 1ns/10ps
`default_nettype none
module ccs_asserts
  import ccs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic [ccs_pkg::ADDR_W-1:0] reg_addr, // Address
  input wire logic reg_rd, // Read strobe
  input wire logic supply_ok, // Supply good
  input wire logic [ccs_pkg::NUM_CARDS-1:0] vcc_overcurrent, // Supply limit
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_clk, // Card clocks
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_rst, // Card resets
  input wire logic [ccs_pkg::NUM_CARDS-1:0] vcc_ramp_en, // Supply ramps
  input wire logic [ccs_pkg::NUM_CARDS-1:0] io_pullup_en, // Pull-ups
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_ground_en, // Grounding
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_io_oe, // I/O pulled low
  input wire logic converter_run, // Converter on
  input wire logic irq_b // Interrupt, low
);
  logic [12:0] up_cnt_reg; // Saturates so a long session cannot wrap
  logic [12:0] up_cnt_next;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Cycles since the card 0 supply ramp began
  always_comb begin
    up_cnt_next = up_cnt_reg;
    if (!vcc_ramp_en[0]) begin
      up_cnt_next = 13'h0000;
    end else if (up_cnt_reg != 13'h1fff) begin
      up_cnt_next = up_cnt_reg + 13'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt_reg <= 13'h0000;
    end else begin
      up_cnt_reg <= up_cnt_next;
    end
  end
  sequence supply_up_s;
    $rose(vcc_ramp_en[0]);
  endsequence
  // Contact order, timing and interrupt checks
  idle_ground_a: assert property (
    card_ground_en[0] |-> !card_rst[0] && !vcc_ramp_en[0] && card_io_oe[0])
    else $error("card 0 contacts live while grounded");
  supply_start_a: assert property (
    supply_up_s |-> $fell(card_ground_en[0]) && converter_run)
    else $error("supply ramp without converter");
  pullup_time_a: assert property (
    $rose(io_pullup_en[0]) |-> up_cnt_reg == 13'h1400)
    else $error("pull-up release at wrong time");
  clock_gate_a: assert property (
    !io_pullup_en[0] |=> !card_clk[0])
    else $error("card clock runs without pull-up");
  reset_high_a: assert property (
    card_rst[0] |-> io_pullup_en[0] && vcc_ramp_en[0])
    else $error("reset high outside session");
  conv_hold_a: assert property (
    vcc_ramp_en != 2'b00 |-> converter_run)
    else $error("converter off while supply on");
  supply_fault_a: assert property (
    vcc_overcurrent[1] && vcc_ramp_en[1] |-> ##[1:3] !irq_b)
    else $error("no interrupt on supply overcurrent");
  irq_hold_a: assert property (
    !irq_b && supply_ok && $past(supply_ok) && !(reg_rd && reg_addr[1]) |=> !irq_b)
    else $error("interrupt released without status read");
endmodule : ccs_asserts
bind card_contact_sequencer ccs_asserts ccs_asserts_inst (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .supply_ok(supply_ok),
  .vcc_overcurrent(vcc_overcurrent), .card_clk(card_clk), .card_rst(card_rst),
  .vcc_ramp_en(vcc_ramp_en), .io_pullup_en(io_pullup_en), .card_ground_en(card_ground_en),
  .card_io_oe(card_io_oe), .converter_run(converter_run), .irq_b(irq_b));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the card contact sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ccs_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, supply_ok, conv, irq_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val, wd;
  logic [NUM_CARDS-1:0] vcc_ovc, clk_src, io_in, io_oe, c_clk, c_rst, vcc_on, sel3, pull, gnd;
  int error_cnt, n_checks, seed, cyc, t0;
  card_contact_sequencer card_contact_sequencer_inst (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .supply_ok(supply_ok), .overheat(1'b0), .card_present(2'b11),
    .vcc_overcurrent(vcc_ovc), .rst_overcurrent(2'b00), .card_clock_source(clk_src),
    .card_io_in(io_in), .card_io_out(), .card_io_oe(io_oe), .host_data_in(2'b11),
    .host_data_out(), .host_data_oe(), .card_clk(c_clk), .card_rst(c_rst),
    .vcc_ramp_en(vcc_on), .vcc_sel_3v(sel3), .io_pullup_en(pull), .card_ground_en(gnd),
    .converter_run(conv), .irq_b(irq_b));
  for (genvar i = 0; i < NUM_CARDS; i++) begin : g_card
    card_model card_model_inst (.pullup_en(pull[i]), .io_oe(io_oe[i]),
      .ground_en(gnd[i]), .io_level(io_in[i]));
  end
  // --------
  // Clocks and hang guard
  // --------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    clk_src <= ~clk_src;
    if (cyc == 110000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      stop_test();
    end
  end
  // --------
  // Helpers
  // --------
  function automatic int gap(input int n);
    return n * SUB_TICK_CYC - 1;
  endfunction : gap
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask : rd
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // Main sequence: both cards up, card 1 fault, card 0 timeout and stop
  initial begin
    seed = 19;
    cyc = 0;
    error_cnt = 0;
    n_checks = 0;
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, vcc_ovc, clk_src} = '0;
    supply_ok = 1'b1;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({gnd, io_oe, conv}, 5'h1e);
    rd(2'b10);
    rd(2'b11);
    repeat (3) @(negedge clk);
    chk(irq_b, 1'b1);
    wr(2'b00, 8'h01);
    t0 = cyc;
    while (conv !== 1'b1) @(negedge clk);
    chk(cyc - t0 <= SUB_TICK_CYC + 6, 1'b1);
    t0 = cyc;
    wd = DATA_W'($random(seed)) | 8'h01; // Random stored bits and run bit
    wr(2'b01, wd);
    while (vcc_on[0] !== 1'b1) @(negedge clk);
    chk(cyc - t0, gap(96));
    rd(2'b01);
    chk({rd_val, sel3}, {wd, wd[CTRL_3V_BIT], 1'b0});
    while (pull[0] !== 1'b1) @(negedge clk);
    @(negedge clk); // I/O drive register follows the pull-up one cycle later
    chk({cyc - t0 - 1, io_oe[0]}, {gap(224), 1'b0});
    while (c_clk[0] !== 1'b1) @(negedge clk);
    chk(cyc - t0 - gap(256) inside {[1:3]} && c_rst[0] === 1'b0, 1'b1);
    t0 = cyc;
    @(posedge clk);
    vcc_ovc <= 2'b10;
    @(posedge clk);
    vcc_ovc <= 2'b00;
    repeat (3) @(negedge clk);
    chk(irq_b, 1'b0);
    rd(2'b01);
    chk(rd_val[CTRL_RUN_BIT], 1'b0);
    rd(2'b11);
    chk(rd_val[STAT_PROTECTION_FAULT_FLAG_BIT], 1'b1);
    rd(2'b11);
    chk({rd_val[STAT_PROTECTION_FAULT_FLAG_BIT], irq_b}, 2'b01);
    while (gnd[1] !== 1'b1) @(negedge clk);
    chk(conv, 1'b1);
    while (c_rst[0] !== 1'b1) @(negedge clk);
    chk(cyc - t0 - 2 * 41950 + 4 inside {[0:8]}, 1'b1);
    wr(2'b00, 8'h00);
    t0 = cyc;
    while (c_rst[0] !== 1'b0) @(negedge clk);
    chk(cyc - t0 <= SUB_TICK_CYC + 6, 1'b1);
    t0 = cyc;
    while (pull[0] !== 1'b0) @(negedge clk);
    @(negedge clk); // I/O pull-low register lags the pull-up being withdrawn
    chk({cyc - t0 - 1, c_clk[0], io_oe[0]}, {gap(64), 2'b01});
    while (vcc_on[0] !== 1'b0) @(negedge clk);
    chk(cyc - t0, gap(96));
    while (gnd[0] !== 1'b1) @(negedge clk);
    chk(cyc - t0, gap(224));
    @(negedge clk);
    chk(conv, 1'b0);
    wr(2'b00, 8'h01);
    wr(2'b01, 8'h01);
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (3) @(negedge clk);
    chk(irq_b, 1'b0);
    for (int i = 0; i < NUM_CARDS; i++) begin
      rd(ADDR_W'(i));
      chk(rd_val[CTRL_RUN_BIT], 1'b0);
    end
    wr(2'b00, 8'h01);
    rd(2'b00);
    chk(rd_val[CTRL_RUN_BIT], 1'b0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// File: rtl/card_contact_sequencer.sv
// Dual card contact sequencer: registers, faults, reset timing, contacts
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module card_contact_sequencer
  import ccs_pkg::*;
(
  input wire logic clk,                                  // System clock 100 MHz
  input wire logic rst_b,                                // Async reset, active low
  input wire logic [ccs_pkg::ADDR_W-1:0] reg_addr,      // Register address
  input wire logic [ccs_pkg::DATA_W-1:0] reg_wdata,     // Write data
  input wire logic reg_wr,                               // Write strobe
  input wire logic reg_rd,                               // Read strobe
  output logic [ccs_pkg::DATA_W-1:0] reg_rdata,         // Read data, next cycle
  input wire logic supply_ok,                            // Supervisor: supply good
  input wire logic overheat,                             // Thermal alarm
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_present,     // Card detect
  input wire logic [ccs_pkg::NUM_CARDS-1:0] vcc_overcurrent,  // Supply limit hit
  input wire logic [ccs_pkg::NUM_CARDS-1:0] rst_overcurrent,  // Reset limit hit
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_clock_source, // Card clock in
  input wire logic [ccs_pkg::NUM_CARDS-1:0] card_io_in,       // Card I/O level
  output logic [ccs_pkg::NUM_CARDS-1:0] card_io_out,          // Card I/O drive
  output logic [ccs_pkg::NUM_CARDS-1:0] card_io_oe,           // Card I/O enable
  input wire logic [ccs_pkg::NUM_CARDS-1:0] host_data_in,     // Host data level
  output logic [ccs_pkg::NUM_CARDS-1:0] host_data_out,        // Host data drive
  output logic [ccs_pkg::NUM_CARDS-1:0] host_data_oe,         // Host data enable
  output logic [ccs_pkg::NUM_CARDS-1:0] card_clk,             // Clock to card
  output logic [ccs_pkg::NUM_CARDS-1:0] card_rst,             // Reset to card
  output logic [ccs_pkg::NUM_CARDS-1:0] vcc_ramp_en,          // Supply ramp up
  output logic [ccs_pkg::NUM_CARDS-1:0] vcc_sel_3v,           // 3 V when high
  output logic [ccs_pkg::NUM_CARDS-1:0] io_pullup_en,         // I/O pull-up on
  output logic [ccs_pkg::NUM_CARDS-1:0] card_ground_en,       // Contacts to ground
  output logic converter_run,                            // Supply converter on
  output logic irq_b                                     // Interrupt, active low
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CARDS-1:0][DATA_W-1:0] ctrl;
    logic [NUM_CARDS-1:0] presl;
    logic [NUM_CARDS-1:0] protection_fault_flag;
    logic [NUM_CARDS-1:0] mute;
    logic supl;
    logic [NUM_CARDS-1:0] pres_q;
    logic [NUM_CARDS-1:0] src_q;
    logic [NUM_CARDS-1:0][ATR_W-1:0] atr_cnt;
    logic [NUM_CARDS-1:0] answered;
    logic [NUM_CARDS-1:0] rst_high;
    logic [NUM_CARDS-1:0] clk_out;
    logic [NUM_CARDS-1:0] rst_out;
    logic [NUM_CARDS-1:0] io_oe;
    logic [NUM_CARDS-1:0] host_oe;
    logic conv;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } top_s;

  top_s r_reg;
  top_s r_next;

  logic sub_tick;
  logic [NUM_CARDS-1:0] seq_conv;
  logic [NUM_CARDS-1:0] seq_vcc;
  logic [NUM_CARDS-1:0] seq_pull;
  logic [NUM_CARDS-1:0] seq_clk;
  logic [NUM_CARDS-1:0] seq_rst;
  logic [NUM_CARDS-1:0] seq_gnd;
  logic [NUM_CARDS-1:0] seq_active;
  logic [NUM_CARDS-1:0] run_bits;

  // Status byte layout, shared by both cards
  function automatic logic [DATA_W-1:0] status_byte(input logic pres, input logic presl,
                                                   input logic io, input logic supl,
                                                   input logic protection_fault_flag, input logic mute,
                                                   input logic act);
    logic [DATA_W-1:0] b;
    b = DATA_ZERO;
    b[STAT_PRES_BIT] = pres;
    b[STAT_PRESL_BIT] = presl;
    b[STAT_IO_BIT] = io;
    b[STAT_SUPL_BIT] = supl;
    b[STAT_PROTECTION_FAULT_FLAG_BIT] = protection_fault_flag;
    b[STAT_MUTE_BIT] = mute;
    b[STAT_ACTIVE_BIT] = act;
    return b;
  endfunction : status_byte

  // ----------------------------------------------------------------------
  // Time base and per-card sequencers
  // ----------------------------------------------------------------------
  // One shared T/64 divider keeps both cards on the same step grid
  step_timebase u_timebase (
    .clk(clk),
    .rst_b(rst_b),
    .sub_tick(sub_tick)
  );

  // Independent sequencer per card
  for (genvar g = 0; g < NUM_CARDS; g++) begin : g_card
    assign run_bits[g] = r_reg.ctrl[g][CTRL_RUN_BIT];
    card_seq u_seq (
      .clk(clk),
      .rst_b(rst_b),
      .sub_tick(sub_tick),
      .run(run_bits[g]),
      .conv_req(seq_conv[g]),
      .vcc_on(seq_vcc[g]),
      .pull_on(seq_pull[g]),
      .clk_on(seq_clk[g]),
      .rst_on(seq_rst[g]),
      .grounded(seq_gnd[g]),
      .active(seq_active[g])
    );
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic card;
    logic allowed;
    logic session;
    logic rst_low;
    logic card_fault;
    logic edge_seen;
    r_next = r_reg;
    card = reg_addr[ADDR_CARD_BIT];
    allowed = 1'b0;
    session = 1'b0;
    rst_low = 1'b0;
    card_fault = 1'b0;
    edge_seen = 1'b0;
    r_next.rdata = DATA_ZERO;
    r_next.src_q = card_clock_source;
    r_next.pres_q = card_present;

    // Control write; a start is refused unless the card may be powered
    if (reg_wr && !reg_addr[ADDR_STAT_BIT]) begin
      allowed = card_present[card] && supply_ok && !overheat && !r_reg.protection_fault_flag[card];
      r_next.ctrl[card] = reg_wdata;
      if (reg_wdata[CTRL_RUN_BIT] && !r_reg.ctrl[card][CTRL_RUN_BIT] && !allowed) begin
        r_next.ctrl[card][CTRL_RUN_BIT] = 1'b0;
      end
    end

    // Reads; a status read clears that card's sticky flags
    if (reg_rd) begin
      if (reg_addr[ADDR_STAT_BIT]) begin
        r_next.rdata = status_byte(card_present[card], r_reg.presl[card], card_io_in[card],
                                   r_reg.supl, r_reg.protection_fault_flag[card], r_reg.mute[card],
                                   seq_active[card]);
        r_next.presl[card] = 1'b0;
        r_next.protection_fault_flag[card] = 1'b0;
        r_next.mute[card] = 1'b0;
        r_next.supl = 1'b0;
      end else begin
        r_next.rdata = r_reg.ctrl[card];
      end
    end

    // Supervisor fault; set after the read so a new event wins
    if (!supply_ok) begin
      r_next.supl = 1'b1;
    end

    for (int i = 0; i < NUM_CARDS; i++) begin
      session = r_reg.ctrl[i][CTRL_RUN_BIT] || seq_active[i];
      rst_low = seq_rst[i] && !r_reg.rst_out[i];

      // Presence change is flagged whether or not a session runs
      if (card_present[i] != r_reg.pres_q[i]) begin
        r_next.presl[i] = 1'b1;
      end

      // Overloads and heat during a session latch the protection flag
      if (session && ((rst_overcurrent[i] && rst_low) || vcc_overcurrent[i] || overheat)) begin
        r_next.protection_fault_flag[i] = 1'b1;
      end

      // Emergency: clearing the run bit makes the sequencer tear down
      card_fault = vcc_overcurrent[i] || (rst_overcurrent[i] && rst_low)
                   || (r_reg.pres_q[i] && !card_present[i] && session);
      if (card_fault || overheat || !supply_ok) begin
        r_next.ctrl[i][CTRL_RUN_BIT] = 1'b0;
      end

      // Answer-to-reset timing, counted on card clock rising edges
      edge_seen = card_clock_source[i] && !r_reg.src_q[i];
      if (!seq_clk[i]) begin
        r_next.atr_cnt[i] = '0;
        r_next.answered[i] = 1'b0;
        r_next.rst_high[i] = 1'b0;
      end else if (!r_reg.answered[i]) begin
        if (seq_pull[i] && !card_io_in[i]) begin
          r_next.answered[i] = 1'b1;           // Start bit seen, count stops
        end else if (edge_seen) begin
          if (r_reg.atr_cnt[i] == ATR_LAST) begin
            r_next.atr_cnt[i] = '0;
            if (!r_reg.rst_high[i]) begin
              r_next.rst_high[i] = 1'b1;
            end else begin
              r_next.mute[i] = 1'b1;
              r_next.answered[i] = 1'b1;
            end
          end else begin
            r_next.atr_cnt[i] = r_reg.atr_cnt[i] + ATR_ONE;
          end
        end
      end

      // Contact drivers; reset falls with the sequencer even if raised
      r_next.clk_out[i] = seq_clk[i] && card_clock_source[i];
      r_next.rst_out[i] = seq_rst[i] && r_next.rst_high[i];
      // I/O pulled low unless released; host path is open-drain both ways
      r_next.io_oe[i] = !seq_pull[i]
                        || (r_reg.ctrl[i][CTRL_IOEN_BIT] && !host_data_in[i]);
      r_next.host_oe[i] = seq_pull[i] && r_reg.ctrl[i][CTRL_IOEN_BIT] && !card_io_in[i];
    end

    // Converter runs while either card needs it
    r_next.conv = |seq_conv;
    r_next.irq = (|r_next.presl) || (|r_next.protection_fault_flag) || (|r_next.mute) || !supply_ok;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Supervisor flag starts set, as after a power-on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.ctrl <= {NUM_CARDS{CTRL_RESET}};
      r_reg.supl <= 1'b1;
      r_reg.io_oe <= '1;
      r_reg.irq <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Only ever drive low: pull-ups provide the high level
  assign card_io_out = '0;
  assign host_data_out = '0;
  assign card_io_oe = r_reg.io_oe;
  assign host_data_oe = r_reg.host_oe;
  assign card_clk = r_reg.clk_out;
  assign card_rst = r_reg.rst_out;
  assign vcc_ramp_en = seq_vcc;
  assign io_pullup_en = seq_pull;
  assign card_ground_en = seq_gnd;
  assign converter_run = r_reg.conv;
  assign irq_b = !r_reg.irq;
  assign reg_rdata = r_reg.rdata;
  for (genvar v = 0; v < NUM_CARDS; v++) begin : g_sel
    assign vcc_sel_3v[v] = r_reg.ctrl[v][CTRL_3V_BIT];
  end

endmodule : card_contact_sequencer
`default_nettype wire

// File: rtl/card_seq.sv
// Activation and deactivation step sequencer for one card
`timescale 1ns/10ps
`default_nettype none
module card_seq
  import ccs_pkg::*;
(
  input wire logic clk,       // System clock
  input wire logic rst_b,     // Async reset, active low
  input wire logic sub_tick,  // T/64 pulse
  input wire logic run,       // Session run bit
  output logic conv_req,      // Converter run request
  output logic vcc_on,        // Card supply ramp enable
  output logic pull_on,       // I/O pull-up released
  output logic clk_on,        // Card clock enabled
  output logic rst_on,        // Reset output enabled (may go high)
  output logic grounded,      // Contacts low impedance to ground
  output logic active         // Sequencer not idle
);

  typedef struct packed {
    seq_state_e st;
    logic [STEP_W-1:0] cnt;
    logic conv;
    logic vcc;
    logic pull;
    logic clk;
    logic rst;
    logic gnd;
  } seq_s;

  seq_s s_reg;
  seq_s s_next;
  logic [STEP_W-1:0] step;

  // --------------------------------------------------------------------
  // Step engine: outputs switch at fixed offsets from the sequence start
  // --------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    step = s_reg.cnt + (sub_tick ? STEP_ONE : '0);
    s_next.cnt = step;
    unique case (s_reg.st)
      SEQ_OFF: begin
        s_next.gnd = 1'b1;
        s_next.cnt = '0;
        if (run) begin
          s_next.st = SEQ_ACT;
        end
      end
      SEQ_ACT: begin
        if (!run) begin
          // Abort mid-activation straight into the teardown
          s_next.st = SEQ_DEACT;
          s_next.cnt = '0;
        end else begin
          if (step >= OFS_CONV) s_next.conv = 1'b1;
          if (step >= OFS_VCC) begin
            s_next.vcc = 1'b1;
            s_next.gnd = 1'b0;
          end
          if (step >= OFS_IO) s_next.pull = 1'b1;
          if (step >= OFS_CLK) begin
            s_next.clk = 1'b1;
            s_next.rst = 1'b1;
            s_next.st = SEQ_ON;
          end
        end
      end
      SEQ_ON: begin
        s_next.cnt = '0;
        if (!run) begin
          s_next.st = SEQ_DEACT;
        end
      end
      SEQ_DEACT: begin
        if (step >= OFS_RST_LOW) s_next.rst = 1'b0;
        if (step >= OFS_CLK_STOP) s_next.clk = 1'b0;
        if (step >= OFS_IO_LOW) s_next.pull = 1'b0;
        if (step >= OFS_VCC_OFF) s_next.vcc = 1'b0;
        if (step >= OFS_GROUND) begin
          s_next.conv = 1'b0;
          s_next.gnd = 1'b1;
          s_next.st = SEQ_OFF;
        end
      end
    endcase
  end

  // State register; contacts grounded out of reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{st: SEQ_OFF, cnt: '0, conv: 1'b0, vcc: 1'b0, pull: 1'b0,
                 clk: 1'b0, rst: 1'b0, gnd: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign conv_req = s_reg.conv;
  assign vcc_on = s_reg.vcc;
  assign pull_on = s_reg.pull;
  assign clk_on = s_reg.clk;
  assign rst_on = s_reg.rst;
  assign grounded = s_reg.gnd;
  assign active = (s_reg.st != SEQ_OFF);

endmodule : card_seq
`default_nettype wire

// File: rtl/ccs_pkg.sv
// Shared constants and types for the card contact sequencer
package ccs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;        // System clock, 100 MHz
  localparam int FINT_PERIOD_NS = 400;      // Internal oscillator, 2.5 MHz
  localparam int T_NS = 25000;              // Step interval T, 25 us
  localparam int SUBS_PER_T = 64;           // T is oscillator divided by 64
  // One sub-step (T/64) in system clocks, rounded down
  localparam int SUB_TICK_CYC = FINT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SUB_CNT_W = 6;
  localparam logic [SUB_CNT_W-1:0] SUB_TICK_LAST = SUB_CNT_W'(SUB_TICK_CYC - 1);

  // Step offsets counted in T/64 units from the request
  localparam int STEP_W = 9;
  localparam logic [STEP_W-1:0] OFS_CONV = STEP_W'(1);
  localparam logic [STEP_W-1:0] OFS_VCC = STEP_W'(1 + 3 * SUBS_PER_T / 2);
  localparam logic [STEP_W-1:0] OFS_IO = STEP_W'(1 + 7 * SUBS_PER_T / 2);
  localparam logic [STEP_W-1:0] OFS_CLK = STEP_W'(1 + 4 * SUBS_PER_T);
  localparam logic [STEP_W-1:0] OFS_RST_LOW = STEP_W'(1);
  localparam logic [STEP_W-1:0] OFS_CLK_STOP = STEP_W'(1 + SUBS_PER_T / 2);
  localparam logic [STEP_W-1:0] OFS_IO_LOW = STEP_W'(1 + SUBS_PER_T);
  localparam logic [STEP_W-1:0] OFS_VCC_OFF = STEP_W'(1 + 3 * SUBS_PER_T / 2);
  localparam logic [STEP_W-1:0] OFS_GROUND = STEP_W'(1 + 7 * SUBS_PER_T / 2);
  localparam logic [STEP_W-1:0] STEP_ONE = STEP_W'(1);

  // Answer-to-reset window in card clock cycles
  localparam int ATR_W = 16;
  localparam logic [ATR_W-1:0] ATR_LAST = ATR_W'(41950 - 1);
  localparam logic [ATR_W-1:0] ATR_ONE = ATR_W'(1);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int NUM_CARDS = 2;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int ADDR_CARD_BIT = 0;         // Selects card 0 or 1
  localparam int ADDR_STAT_BIT = 1;         // 0 control, 1 status
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_3V_BIT = 2;
  localparam int CTRL_IOEN_BIT = 7;
  localparam int STAT_PRES_BIT = 0;
  localparam int STAT_PRESL_BIT = 1;
  localparam int STAT_IO_BIT = 2;
  localparam int STAT_SUPL_BIT = 3;
  localparam int STAT_PROTECTION_FAULT_FLAG_BIT = 4;
  localparam int STAT_MUTE_BIT = 5;
  localparam int STAT_ACTIVE_BIT = 7;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_ACT = 2'b01,
    SEQ_ON = 2'b10,
    SEQ_DEACT = 2'b11
  } seq_state_e;

endpackage : ccs_pkg

// File: rtl/step_timebase.sv
// Divider giving one pulse per oscillator period (T/64)
`timescale 1ns/10ps
`default_nettype none
module step_timebase
  import ccs_pkg::*;
(
  input wire logic clk,    // System clock
  input wire logic rst_b,  // Async reset, active low
  output logic sub_tick    // One-cycle pulse every T/64
);

  typedef struct packed {
    logic [SUB_CNT_W-1:0] cnt;
    logic tick;
  } tb_state_s;

  tb_state_s tb_reg;
  tb_state_s tb_next;

  // Free-running divider; tick is registered to keep it glitch free
  always_comb begin
    tb_next = tb_reg;
    tb_next.tick = (tb_reg.cnt == SUB_TICK_LAST);
    tb_next.cnt = tb_next.tick ? '0 : tb_reg.cnt + STEP_ONE[SUB_CNT_W-1:0];
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_reg <= '0;
    end else begin
      tb_reg <= tb_next;
    end
  end

  assign sub_tick = tb_reg.tick;

endmodule : step_timebase
`default_nettype wire
